/* File: src/tai_pkg.sv */
// constants shared by the thermal alarm i2c slave
package tai_pkg;
    // seven-bit slave address: group 1001, device 000
    localparam logic [6:0] SLAVE_ADDR = 7'h48;
    // register offsets
    localparam logic [7:0] A_TEMP  = 8'h00;
    localparam logic [7:0] A_MASK1 = 8'h05;
    localparam logic [7:0] A_MASK2 = 8'h06;
    localparam logic [7:0] A_FLAG1 = 8'h07;
    localparam logic [7:0] A_FLAG2 = 8'h08;
    localparam logic [7:0] A_CFG   = 8'h0C;
    localparam logic [7:0] A_HOT   = 8'h0D;
    localparam logic [7:0] A_COOL  = 8'h0E;
    localparam logic [7:0] A_PIN   = 8'h11;
    // reset values
    localparam logic [7:0] RST_MASK1 = 8'h74;
    localparam logic [7:0] RST_MASK2 = 8'hFB;
    localparam logic [7:0] RST_HOT   = 8'h32;
    localparam logic [7:0] RST_COOL  = 8'h2D;
    localparam logic [1:0] RST_FQSEL = 2'h0;
    // bits of irq_flags_one and irq_mask_one
    localparam int B_HOT   = 2;
    localparam int B_COOL  = 3;
    localparam int B_BOOST = 4;
    localparam int B_LOCK  = 5;
    localparam int B_TRIP  = 6;
    // bits of irq_flags_two and irq_mask_two
    localparam int B_INV = 0;
    localparam int B_EOC = 2;
    // bits of sensor_cfg_reg
    localparam int B_TRIG  = 7;
    localparam int B_CEND  = 5;
    localparam int B_FQ    = 3;
    localparam int B_FQCLR = 2;
    // bit of the pinned read register
    localparam int B_PIN = 0;
    // clamp limits of the result, -10 and 85 degrees
    localparam logic [7:0] TEMP_MIN = 8'hF6;
    localparam logic [7:0] TEMP_MAX = 8'h55;
    // consecutive reading counts for selector values 0..3
    localparam logic [2:0] FQ_N0 = 3'h1;
    localparam logic [2:0] FQ_N1 = 3'h2;
    localparam logic [2:0] FQ_N2 = 3'h4;
    localparam logic [2:0] FQ_N3 = 3'h6;
    // timing
    localparam int CLK_MHZ     = 200;
    localparam int TICK_US     = 1;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam int REASSERT_US = 32;
    localparam int AUTO_S      = 60;
    localparam int AUTO_US     = AUTO_S * 1000000;
    // link state machine
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_AACK, ST_SUB, ST_SACK,
        ST_WR, ST_WACK, ST_RD, ST_RACK
    } tai_state_t;
endpackage

/* File: src/tai_pin_sync.sv */
// three-flop synchroniser with agreement filter for pin inputs
`timescale 1ns/100ps
module tai_pin_sync #(
    parameter int W = 6
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // raw pins and filtered levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // a level counts only once stages two and three agree, so one-cycle spikes die here
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                s1_q[i] <= 1'b1;
                s2_q[i] <= 1'b1;
                s3_q[i] <= 1'b1;
                q[i]    <= 1'b1;
            end else begin
                s1_q[i] <= d[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                if (s2_q[i] == s3_q[i]) begin
                    q[i] <= s3_q[i];
                end
            end
        end
    end
endmodule // tai_pin_sync

/* File: src/tai_thermal_alarm_i2c_slave.sv */
// thermal alarm compare, fault queue and i2c slave register access
// Functional notes
// - result above hot limit sets flag, interrupt
// - hot mask zero suppresses hot interrupt
// - after hot, below cool gives cool interrupt
// - after hot: hot again, cool, or done
// - hot needs 1, 2, 4 or 6 readings
// - queue clears below limit or on write
// - autonomous variant converts every 60 seconds
// - pinned read returns result, no increment
// - writes work normally whatever pinned bit
// - autonomous variant re-enables rails without clearing
// - slave up to 400 kbit/s, auto-increment
// - slave address 1001 000
// - start and stop seen while clock high
// - matching address acknowledged, subaddress follows
// - every byte acknowledged, address then advances
// - reading flags clears; persisting fault reasserts
// - masks gate only the interrupt pin
// - result clamped to -10 .. 85 degrees
// - conversion end clears trigger, sets done flag
`timescale 1ns/100ps
module tai_thermal_alarm_i2c_slave #(
    parameter int AUTONOMOUS     = 1,
    parameter int AUTO_PERIOD_US = tai_pkg::AUTO_US
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // i2c link pins
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    // open-drain interrupt pin
    output logic            irq_out_n,
    output logic            irq_oe,
    // converter handshake
    output logic            conv_start,
    input  wire logic       conv_done,
    input  wire logic [7:0] conv_data,
    // fault conditions and rail permission
    input  wire logic       thermal_trip,
    input  wire logic       boost_low_fault,
    input  wire logic       inverter_low_fault,
    input  wire logic       input_low_lockout,
    output logic            rails_reenable_ok,
    // status
    output logic            hot_alarm_flag
);
    import tai_pkg::*;

    localparam int AW = $clog2(AUTO_PERIOD_US + 1);

    logic [5:0]  pins_s;
    logic        scl_s, sda_s, scl_p_q, sda_p_q;
    logic [3:0]  flt_s, flt_p_q;
    tai_state_t  st_q, st_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [7:0]  sh_q, sh_d, tx_q, tx_d, ptr_q, ptr_d;
    logic        rw_q, rw_d, oe_q, oe_d, wr_stb, rd_load;
    logic [7:0]  mask1_q, mask2_q, hot_q, cool_q, flag1_q, flag2_q, temp_q;
    logic        pin_q, trig_q, busy_q, hot_mode_q, auto_due_q, start_q;
    logic [1:0]  fq_sel_q;
    logic [2:0]  fq_cnt_q;
    logic [7:0]  tick_cnt_q;
    logic [AW-1:0] auto_cnt_q;
    logic        irq_q, irq_n_q, rails_q;

    // pins pass the three-flop filter before any edge is looked at
    tai_pin_sync #(.W(6)) u_sync (
        .clk   (clk),
        .reset (reset),
        .d     ({input_low_lockout, inverter_low_fault, boost_low_fault,
                 thermal_trip, sda_i, scl_i}),
        .q     (pins_s)
    );

    // link events; a few cycles of latency is nothing against 2.5 us bits
    wire scl_rise = scl_s & ~scl_p_q;
    wire scl_fall = ~scl_s & scl_p_q;
    wire start_c  = scl_s & scl_p_q & sda_p_q & ~sda_s;
    wire stop_c   = scl_s & scl_p_q & ~sda_p_q & sda_s;
    assign scl_s = pins_s[0];
    assign sda_s = pins_s[1];
    assign flt_s = pins_s[5:2];

    // register write decode, the pinned bit plays no part here
    wire wr_mask1 = wr_stb && ptr_q == A_MASK1;
    wire wr_mask2 = wr_stb && ptr_q == A_MASK2;
    wire wr_cfg   = wr_stb && ptr_q == A_CFG;
    wire wr_hot   = wr_stb && ptr_q == A_HOT;
    wire wr_cool  = wr_stb && ptr_q == A_COOL;
    wire wr_pin   = wr_stb && ptr_q == A_PIN;
    wire fq_clr   = wr_cfg && sh_q[B_FQCLR];

    // read selection; a pinned pointer always serves the result
    wire [7:0] cfg_rd = {trig_q, 1'b0, ~busy_q, fq_sel_q, 3'h0};
    wire [7:0] reg_rd = (ptr_q == A_TEMP)  ? temp_q  :
                        (ptr_q == A_MASK1) ? mask1_q :
                        (ptr_q == A_MASK2) ? mask2_q :
                        (ptr_q == A_FLAG1) ? flag1_q :
                        (ptr_q == A_FLAG2) ? flag2_q :
                        (ptr_q == A_CFG)   ? cfg_rd  :
                        (ptr_q == A_HOT)   ? hot_q   :
                        (ptr_q == A_COOL)  ? cool_q  :
                        (ptr_q == A_PIN)   ? {7'h00, pin_q} : 8'h00;
    wire [7:0] rd_byte = pin_q ? temp_q : reg_rd;
    wire rd_clr1 = rd_load && !pin_q && ptr_q == A_FLAG1;
    wire rd_clr2 = rd_load && !pin_q && ptr_q == A_FLAG2;

    // converter result, clamp and compare
    wire       res_vld = conv_done & busy_q;
    wire [7:0] tc = ($signed(conv_data) < $signed(TEMP_MIN)) ? TEMP_MIN :
                    ($signed(conv_data) > $signed(TEMP_MAX)) ? TEMP_MAX : conv_data;
    wire       above = $signed(tc) > $signed(hot_q);
    wire       below = $signed(tc) < $signed(cool_q);
    wire [2:0] need  = (fq_sel_q == 2'h0) ? FQ_N0 : (fq_sel_q == 2'h1) ? FQ_N1 :
                       (fq_sel_q == 2'h2) ? FQ_N2 : FQ_N3;
    wire [2:0] fq_inc = (fq_cnt_q == 3'h7) ? 3'h7 : fq_cnt_q + 3'h1;
    wire       meet   = above && fq_inc >= need;
    wire       hot_ev  = res_vld && meet;
    wire       cool_ev = res_vld && hot_mode_q && below;

    // converter kick: host trigger or the periodic timer, one at a time
    wire tick     = tick_cnt_q == 8'(TICK_CYCLES - 1);
    wire auto_hit = AUTONOMOUS != 0 && tick && auto_cnt_q == AW'(AUTO_PERIOD_US - 1);
    wire go_conv  = !busy_q && (trig_q || auto_due_q);

    // flags: edges set at once, a standing fault again on every tick
    wire [3:0] flt_ev = flt_s & (~flt_p_q | {4{tick}});
    wire [7:0] set1 = (8'(hot_ev) << B_HOT) | (8'(cool_ev) << B_COOL) |
                      (8'(flt_ev[0]) << B_TRIP) | (8'(flt_ev[1]) << B_BOOST) |
                      (8'(flt_ev[3]) << B_LOCK);
    wire [7:0] set2 = (8'(res_vld) << B_EOC) | (8'(flt_ev[2]) << B_INV);
    wire       pend = |(flag1_q & mask1_q) || |(flag2_q & mask2_q);
    wire       flt_flag = flag1_q[B_TRIP] | flag1_q[B_BOOST] | flag1_q[B_LOCK] |
                          flag2_q[B_INV];
    wire       rails_d = !(|flt_s) && (AUTONOMOUS != 0 || !flt_flag);

    // slave state machine; data sampled on scl rise, driven after scl fall
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        tx_d = tx_q;
        oe_d = oe_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        wr_stb = 1'b0;
        rd_load = 1'b0;
        if (start_c) begin
            st_d = ST_ADDR;
            cnt_d = 4'h0;
            oe_d = 1'b0;
        end else if (stop_c) begin
            st_d = ST_IDLE;
            oe_d = 1'b0;
        end else begin
            case (st_q)
                ST_ADDR, ST_SUB, ST_WR: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sda_s};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == 4'h8) begin
                        cnt_d = 4'h0;
                        oe_d = 1'b1;
                        if (st_q == ST_ADDR) begin
                            rw_d = sh_q[0];
                            st_d = ST_AACK;
                            if (sh_q[7:1] != SLAVE_ADDR) begin
                                st_d = ST_IDLE;
                                oe_d = 1'b0;
                            end
                        end else if (st_q == ST_SUB) begin
                            ptr_d = sh_q;
                            st_d = ST_SACK;
                        end else begin
                            wr_stb = 1'b1;
                            ptr_d = ptr_q + 8'h01;
                            st_d = ST_WACK;
                        end
                    end
                end
                ST_AACK, ST_SACK, ST_WACK: begin
                    if (scl_fall) begin
                        oe_d = 1'b0;
                        st_d = (st_q == ST_AACK) ? ST_SUB : ST_WR;
                        rd_load = (st_q == ST_AACK) && rw_q;
                    end
                end
                ST_RD: begin
                    if (scl_fall && cnt_q == 4'h7) begin
                        oe_d = 1'b0;
                        cnt_d = 4'h0;
                        st_d = ST_RACK;
                    end else if (scl_fall) begin
                        tx_d = {tx_q[6:0], 1'b0};
                        oe_d = ~tx_q[6];
                        cnt_d = cnt_q + 4'h1;
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        sh_d = {7'h00, sda_s}; // master acknowledge, low means more
                    end else if (scl_fall) begin
                        st_d = ST_IDLE;
                        rd_load = !sh_q[0];
                    end
                end
                default: ;
            endcase
        end
        // reads advance the pointer only when it is not pinned
        if (rd_load) begin
            st_d = ST_RD;
            tx_d = rd_byte;
            oe_d = ~rd_byte[7];
            cnt_d = 4'h0;
            ptr_d = pin_q ? ptr_q : ptr_q + 8'h01;
        end
    end

    // link registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q <= ST_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            oe_q <= 1'b0;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            flt_p_q <= 4'hF; // filter leaves reset high; avoids a false fault edge
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            tx_q <= tx_d;
            oe_q <= oe_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
            flt_p_q <= flt_s;
        end
    end

    // host-written registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mask1_q <= RST_MASK1;
            mask2_q <= RST_MASK2;
            hot_q <= RST_HOT;
            cool_q <= RST_COOL;
            pin_q <= 1'b0;
            fq_sel_q <= RST_FQSEL;
        end else begin
            if (wr_mask1) mask1_q <= sh_q;
            if (wr_mask2) mask2_q <= sh_q;
            if (wr_hot) hot_q <= sh_q;
            if (wr_cool) cool_q <= sh_q;
            if (wr_pin) pin_q <= sh_q[B_PIN];
            if (wr_cfg) fq_sel_q <= sh_q[B_FQ+1:B_FQ];
        end
    end

    // conversion control; a host write of the trigger beats the hardware clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            trig_q <= 1'b0;
            busy_q <= 1'b0;
            start_q <= 1'b0;
            auto_due_q <= 1'b0;
            tick_cnt_q <= 8'h00;
            auto_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick ? 8'h00 : tick_cnt_q + 8'h01;
            if (tick) auto_cnt_q <= auto_hit ? '0 : auto_cnt_q + AW'(1);
            auto_due_q <= auto_hit || (auto_due_q && !go_conv);
            start_q <= go_conv;
            busy_q <= go_conv || (busy_q && !conv_done);
            if (wr_cfg) trig_q <= sh_q[B_TRIG];
            else if (res_vld) trig_q <= 1'b0;
        end
    end

    // alarm state, fault queue, result and flags; set beats read clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            temp_q <= 8'h00;
            hot_mode_q <= 1'b0;
            fq_cnt_q <= 3'h0;
            flag1_q <= 8'h00;
            flag2_q <= 8'h00;
            irq_q <= 1'b0;
            irq_n_q <= 1'b1;
            rails_q <= 1'b0;
        end else begin
            if (res_vld) temp_q <= tc;
            if (hot_ev) hot_mode_q <= 1'b1;
            else if (cool_ev) hot_mode_q <= 1'b0;
            if (fq_clr) fq_cnt_q <= 3'h0;
            else if (res_vld) fq_cnt_q <= above ? fq_inc : 3'h0;
            flag1_q <= (rd_clr1 ? 8'h00 : flag1_q) | set1;
            flag2_q <= (rd_clr2 ? 8'h00 : flag2_q) | set2;
            irq_q <= pend;
            irq_n_q <= !pend; // pin level from its own flop
            rails_q <= rails_d;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe = oe_q;
    assign irq_out_n = irq_n_q;
    assign irq_oe = irq_q;
    assign conv_start = start_q;
    assign rails_reenable_ok = rails_q;
    assign hot_alarm_flag = flag1_q[B_HOT];

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_hot_seen;
        res_vld && meet && mask1_q[B_HOT];
    endsequence
    sequence s_addr_hit;
        st_q == ST_ADDR && scl_fall && !start_c && !stop_c && cnt_q == 4'h8 &&
            sh_q[7:1] == SLAVE_ADDR;
    endsequence
    property p_hot_irq;
        s_hot_seen |-> ##2 irq_oe && !irq_out_n && hot_alarm_flag;
    endproperty
    a_hot_irq: assert property (p_hot_irq) else $error("hot not reported");
    property p_mask;
        !pend |=> !irq_oe;
    endproperty
    a_mask: assert property (p_mask) else $error("masked irq seen");
    property p_cool;
        res_vld && hot_mode_q && below && !meet |=> flag1_q[B_COOL] && !hot_mode_q;
    endproperty
    a_cool: assert property (p_cool) else $error("cool missed");
    property p_between;
        res_vld && hot_mode_q && !above && !below |=> hot_mode_q && flag2_q[B_EOC];
    endproperty
    a_between: assert property (p_between) else $error("between limits wrong");
    property p_fq;
        res_vld && !above |=> fq_cnt_q == 3'h0;
    endproperty
    a_fq: assert property (p_fq) else $error("queue not reset");
    property p_auto;
        auto_due_q && !busy_q |=> conv_start && busy_q;
    endproperty
    a_auto: assert property (p_auto) else $error("periodic start lost");
    property p_done;
        res_vld && !wr_cfg |=> !trig_q && flag2_q[B_EOC];
    endproperty
    a_done: assert property (p_done) else $error("done not handled");
    property p_start;
        start_c |=> st_q == ST_ADDR && cnt_q == 4'h0 && !sda_oe;
    endproperty
    a_start: assert property (p_start) else $error("start not seen");
    property p_pinned;
        rd_load && pin_q |=> tx_q == temp_q && ptr_q == $past(ptr_q);
    endproperty
    a_pinned: assert property (p_pinned) else $error("pinned read wrong");
    property p_addr;
        s_addr_hit |=> sda_oe && st_q == ST_AACK;
    endproperty
    a_addr: assert property (p_addr) else $error("address not acked");
    property p_wr_inc;
        wr_stb && !start_c |=> ptr_q == $past(ptr_q) + 8'h01 && sda_oe;
    endproperty
    a_wr_inc: assert property (p_wr_inc) else $error("write not advanced");
    property p_clamp;
        res_vld |=> $signed(temp_q) >= $signed(TEMP_MIN) && $signed(temp_q) <= $signed(TEMP_MAX);
    endproperty
    a_clamp: assert property (p_clamp) else $error("result out of range");
endmodule // tai_thermal_alarm_i2c_slave

/* File: test/tai_i2c_host.sv */
// i2c bus master model that drives the slave's link
`timescale 1ns/100ps
module tai_i2c_host (
    // link pins: clock, data pull-down, wired data level
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    localparam time Q = 16ns;
    // both lines idle released; scl stands still between frames
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end
    // one 64 ns bit; data moves only while scl is low
    task automatic bit_io(input logic b, output logic r);
        #Q sda_low = ~b;
        #Q scl = 1'b1;
        #(2*Q) r = sda;
        scl = 1'b0;
    endtask
    // start or repeated start: sda falls while scl high
    task automatic start();
        #Q sda_low = 1'b0;
        #Q scl = 1'b1;
        #Q sda_low = 1'b1;
        #Q scl = 1'b0;
    endtask
    // stop, then bus free time before any new start
    task automatic stop();
        #Q sda_low = 1'b1;
        #Q scl = 1'b1;
        #Q sda_low = 1'b0;
        #(8*Q);
    endtask
    // byte out, slave answer returned (0 = acknowledged)
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, ack);
    endtask
    // byte in; last byte is refused so the slave lets go
    task automatic rbyte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, b[i]);
        end
        bit_io(last, r);
    endtask
endmodule // tai_i2c_host

/* File: test/tai_thermal_alarm_i2c_slave_bench.sv */
// self-checking bench for the thermal alarm i2c slave
`timescale 1ns/100ps
module tai_thermal_alarm_i2c_slave_bench;
    import tai_pkg::*;
    logic       clk, reset, scl, host_low, sda_o, sda_oe, irq_out_n, irq_oe;
    logic       conv_start, conv_done, hot_alarm_flag, rails_ok, a;
    logic [3:0] flt_in;
    logic [7:0] conv_data, cur_temp, cfg_v, d0, d1;
    logic [3:0] cwait_q;
    wire logic  sda;
    int         fails, checks_done, conv_n;
    // open-drain data line with pull-up
    assign sda = ~(host_low | (sda_oe & ~sda_o));
    tai_i2c_host host (.scl(scl), .sda_low(host_low), .sda(sda));
    // short auto period so the timer fires within the run
    tai_thermal_alarm_i2c_slave #(.AUTONOMOUS(1), .AUTO_PERIOD_US(250)) uut (
        .clk(clk), .reset(reset), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .irq_out_n(irq_out_n), .irq_oe(irq_oe),
        .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data),
        .thermal_trip(flt_in[0]), .boost_low_fault(flt_in[1]),
        .inverter_low_fault(flt_in[2]), .input_low_lockout(flt_in[3]),
        .rails_reenable_ok(rails_ok),
        .hot_alarm_flag(hot_alarm_flag));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // converter model: answers a few cycles after each start pulse
    always @(posedge clk) begin
        if (reset) begin
            conv_done <= 1'b0;
            conv_data <= 8'h00;
            cwait_q   <= 4'h0;
            conv_n    <= 0;
        end else begin
            conv_done <= 1'b0;
            if (conv_start) begin
                cwait_q <= 4'h4;
            end else if (cwait_q == 4'h1) begin
                conv_done <= 1'b1;
                conv_data <= cur_temp;
                conv_n    <= conv_n + 1;
                cwait_q   <= 4'h0;
            end else if (cwait_q != 4'h0) begin
                cwait_q <= cwait_q - 4'h1;
            end
        end
    end
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic send(input logic [7:0] b);
        host.wbyte(b, a);
        check("ack", 8'(a), 8'h00);
    endtask
    task automatic wr(input logic [7:0] sub, input logic [7:0] x, input logic [7:0] y,
                      input logic two);
        host.start();
        send({SLAVE_ADDR, 1'b0});
        send(sub);
        send(x);
        if (two) begin
            send(y);
        end
        host.stop();
    endtask
    // subaddress write, repeated start, two bytes read
    task automatic rd(input logic [7:0] sub);
        host.start();
        send({SLAVE_ADDR, 1'b0});
        send(sub);
        host.start();
        send({SLAVE_ADDR, 1'b1});
        host.rbyte(1'b0, d0);
        host.rbyte(1'b1, d1);
        host.stop();
    endtask
    // trigger one conversion and wait for its result to land
    task automatic convert(input logic [7:0] t);
        int n0;
        n0 = conv_n;
        cur_temp = t;
        wr(A_CFG, cfg_v | 8'h80, 8'h00, 1'b0);
        for (int i = 0; i < 400 && conv_n == n0; i++) begin
            @(posedge clk);
        end
        check("conversion", 8'(conv_n - n0), 8'h01);
        repeat (10) @(posedge clk);
    endtask
    task automatic t_regs();
        rd(A_MASK1);
        check("mask one", d0, RST_MASK1);
        check("mask two", d1, RST_MASK2);
        rd(A_HOT);
        check("hot limit", d0, RST_HOT);
        check("cool limit", d1, RST_COOL);
        host.start();
        host.wbyte({SLAVE_ADDR ^ 7'h01, 1'b0}, a);
        host.stop();
        check("foreign ack", 8'(a), 8'h01);
        check("data drive", 8'(sda_o), 8'h00);
        $display("regs done");
    endtask
    task automatic t_hot();
        wr(A_HOT, 8'h1E, 8'h14, 1'b1);
        cfg_v = 8'h00;
        convert(8'h28);
        check("hot pin", 8'(irq_out_n), 8'h00);
        check("hot drive", 8'(irq_oe), 8'h01);
        check("hot status", 8'(hot_alarm_flag), 8'h01);
        rd(A_CFG);
        check("cfg", d0, 8'h20);
        rd(A_FLAG1);
        check("hot flag", d0 & 8'h04, 8'h04);
        check("pin released", 8'(irq_out_n), 8'h01);
        wr(A_MASK1, 8'h70, 8'h00, 1'b0);
        convert(8'h28);
        check("masked pin", 8'(irq_out_n), 8'h01);
        check("masked flag", 8'(hot_alarm_flag), 8'h01);
        rd(A_FLAG1);
        $display("hot done");
    endtask
    task automatic t_cool();
        wr(A_MASK1, 8'h7C, 8'h00, 1'b0);
        convert(8'h19);
        check("between pin", 8'(irq_out_n), 8'h01);
        convert(8'h0A);
        check("cool pin", 8'(irq_out_n), 8'h00);
        rd(A_FLAG1);
        check("cool flag", d0 & 8'h0C, 8'h08);
        $display("cool done");
    endtask
    task automatic t_queue();
        cfg_v = 8'h08;
        convert(8'h28);
        check("first of two", 8'(hot_alarm_flag), 8'h00);
        convert(8'h28);
        check("second of two", 8'(hot_alarm_flag), 8'h01);
        rd(A_FLAG1);
        wr(A_CFG, 8'h0C, 8'h00, 1'b0);
        convert(8'h28);
        check("after clear", 8'(hot_alarm_flag), 8'h00);
        cfg_v = 8'h00;
        $display("queue done");
    endtask
    task automatic t_clamp();
        convert(8'h7F);
        rd(A_TEMP);
        check("clamp high", d0, TEMP_MAX);
        convert(8'h80);
        rd(A_TEMP);
        check("clamp low", d0, TEMP_MIN);
        $display("clamp done");
    endtask
    task automatic t_pin();
        wr(A_PIN, 8'h01, 8'h00, 1'b0);
        wr(A_HOT, 8'h33, 8'h15, 1'b1);
        host.start();
        send({SLAVE_ADDR, 1'b1});
        host.rbyte(1'b0, d0);
        host.rbyte(1'b1, d1);
        host.stop();
        check("pinned first", d0, TEMP_MIN);
        check("pinned second", d1, TEMP_MIN);
        wr(A_PIN, 8'h00, 8'h00, 1'b0);
        rd(A_HOT);
        check("write while pinned", d0, 8'h33);
        $display("pinned done");
    endtask
    task automatic t_fault();
        @(posedge clk);
        flt_in <= 4'hF;
        repeat (8) @(posedge clk);
        check("rails held", 8'(rails_ok), 8'h00);
        rd(A_FLAG1);
        check("fault flags one", d0 & 8'h70, 8'h70);
        check("fault flags two", d1 & 8'h01, 8'h01);
        for (int i = 0; i < 6600 && irq_out_n; i++) begin
            @(posedge clk);
        end
        check("pin again", 8'(irq_out_n), 8'h00);
        @(posedge clk);
        flt_in <= 4'h0;
        repeat (8) @(posedge clk);
        check("rails free", 8'(rails_ok), 8'h01);
        $display("fault done");
    endtask
    task automatic t_auto();
        int n0;
        n0 = conv_n;
        for (int i = 0; i < 51000 && conv_n == n0; i++) begin
            @(posedge clk);
        end
        check("timed conversion", 8'(conv_n - n0), 8'h01);
        $display("auto done");
    endtask
    initial begin
        reset = 1'b1;
        flt_in = 4'h0;
        cur_temp = 8'h19;
        cfg_v = 8'h00;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        repeat (10) @(posedge clk);
        t_regs();
        t_hot();
        t_cool();
        t_queue();
        t_clamp();
        t_pin();
        t_fault();
        t_auto();
        stop_test();
    end
    // watchdog sized for the timed conversion wait plus the link traffic
    initial begin
        #500us;
        fails++;
        stop_test();
    end
endmodule // tai_thermal_alarm_i2c_slave_bench
